// ==== hw/metering_event_status_irq.sv ====
/*
 event status latching, read-to-clear, interrupt enable gating and
 energy direction change detection for the metering device.
 assumes detector levels and signed energy accumulators come from logic on
 clk; wishbone master is classic single cycle.
*/
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module metering_event_status_irq
	import event_irq_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire wb_req_t wb_req,
	output var wb_rsp_t wb_rsp,
	input wire det_t det,
	input wire energy_vec_t energy,
	output logic irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] flags_first;
		logic [15:0] flags_second;
		logic [15:0] en_first;
		logic [15:0] en_second;
		logic [15:0] mode_first;
		logic [DIR_CHANNELS-1:0] dir_neg;
		logic [DIR_CHANNELS-1:0] dir_known;
		energy_vec_t ref_val;
		logic ack;
		logic [15:0] rdat;
		logic irq;
	} state_t;

	state_t state_reg;
	state_t state_next;
	logic [DIR_CHANNELS-1:0] dir_event;
	logic [DIR_CHANNELS-1:0] dir_neg_now;
	logic [DIR_CHANNELS-1:0] dir_moved;
	logic [ENERGY_W-1:0] step;
	logic [15:0] set_first;
	logic [15:0] set_second;
	logic access;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
		input logic [1:0] sel, input logic [15:0] mask);
		logic [15:0] r;
		r = old;
		if (sel[0])
			r[7:0] = wd[7:0];
		if (sel[1])
			r[15:8] = wd[15:8];
		return r & mask;
	endfunction

	// ----------------------------------------
	// direction change detection
	// ----------------------------------------
	// only moves of at least one step count, so noise below resolution is ignored
	assign step = state_reg.mode_first[BIT_RESOLUTION] ? STEP_FINE : STEP_COARSE;

	genvar g;
	generate
		for (g = 0; g < DIR_CHANNELS; g++) begin : g_dir
			logic [ENERGY_W-1:0] diff;
			logic [ENERGY_W-1:0] mag;
			assign diff = energy[g] - state_reg.ref_val[g];
			assign dir_neg_now[g] = diff[ENERGY_W-1];
			assign mag = diff[ENERGY_W-1] ? (~diff + 32'h0000_0001) : diff;
			assign dir_moved[g] = (mag >= step);
			assign dir_event[g] = dir_moved[g] && state_reg.dir_known[g]
				&& (dir_neg_now[g] != state_reg.dir_neg[g]);
		end
	endgenerate

	// ----------------------------------------
	// event sets
	// ----------------------------------------
	always_comb begin
		set_first = RESET_WORD;
		set_first[BIT_CHECKSUM_TWO] = det.checksum_two_error;
		set_first[BIT_VOLT_SEQ] = det.voltage_sequence_error;
		set_first[BIT_CURR_SEQ] = det.current_sequence_error;
		set_first[BIT_DIP] = det.voltage_dip_flag;
		set_first[BIT_PHASE_MISSING] = det.phase_missing_flag;
		set_second = RESET_WORD;
		set_second[BIT_SAMPLED_NEUTRAL] = det.sampled_neutral_over;
		set_second[BIT_CALC_NEUTRAL] = det.calc_neutral_over;
		set_second[BIT_VOLT_DIST] = det.voltage_distortion_over;
		set_second[BIT_CURR_DIST] = det.current_distortion_over;
		set_second[BIT_HARMONIC] = det.harmonic_result_ready;
		set_second[DIR_CHANNELS-1:0] = dir_event;
	end

	assign access = wb_req.cyc && wb_req.stb && !state_reg.ack;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.ack = access;
		for (int i = 0; i < DIR_CHANNELS; i++) begin
			if (dir_moved[i]) begin
				state_next.ref_val[i] = energy[i];
				state_next.dir_neg[i] = dir_neg_now[i];
				state_next.dir_known[i] = 1'b1;
			end
		end
		if (access && !wb_req.we) begin
			unique case (wb_req.adr)
				ADDR_FLAGS_FIRST: state_next.rdat = state_reg.flags_first;
				ADDR_FLAGS_SECOND: state_next.rdat = state_reg.flags_second;
				ADDR_EN_FIRST: state_next.rdat = state_reg.en_first;
				ADDR_EN_SECOND: state_next.rdat = state_reg.en_second;
				ADDR_MODE_FIRST: state_next.rdat = state_reg.mode_first;
				default: state_next.rdat = RESET_WORD;
			endcase
			// read clears; a set in the same cycle wins below
			if (wb_req.adr == ADDR_FLAGS_SECOND)
				state_next.flags_second = RESET_WORD;
			if (wb_req.adr == ADDR_FLAGS_FIRST)
				state_next.flags_first = RESET_WORD;
		end
		if (access && wb_req.we) begin
			unique case (wb_req.adr)
				ADDR_EN_FIRST: state_next.en_first = merge(state_reg.en_first,
					wb_req.dat, wb_req.sel, EN_FIRST_MASK);
				ADDR_EN_SECOND: state_next.en_second = merge(state_reg.en_second,
					wb_req.dat, wb_req.sel, EN_SECOND_MASK);
				ADDR_MODE_FIRST: state_next.mode_first = merge(state_reg.mode_first,
					wb_req.dat, wb_req.sel, MODE_FIRST_MASK);
				default: begin
				end
			endcase
		end
		state_next.flags_first = state_next.flags_first | set_first;
		state_next.flags_second = state_next.flags_second | set_second;
		// bitwise gating: first enable covers bits 10,7,6,3,2; second all flags
		state_next.irq = |(state_next.flags_first & state_next.en_first
			& EN_FIRST_MASK)
			|| |(state_next.flags_second & state_next.en_second
			& EN_SECOND_MASK);
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= '0;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	assign wb_rsp.ack = state_reg.ack;
	assign wb_rsp.dat = state_reg.rdat;
	assign irq = state_reg.irq;
endmodule
`default_nettype wire

// ==== hw/event_irq_pkg.sv ====
/*
 holds register offsets, field positions, reset values and carrier structs
 for the metering event status and interrupt enable block.
 assumes a classic wishbone master with word addressing of 16-bit registers.
*/
// Contract
// - second status word at 02H, read clears
// - bit 15 sampled neutral over threshold
// - bit 14 calculated neutral over threshold
// - bit 11 voltage distortion over threshold
// - bit 10 current distortion over threshold
// - bit 9 harmonic results ready
// - bits 7..0 energy direction change flags
// - direction from energy register, resolution selectable
// - first status bit 2 phase loss
// - first enable word at 03H, reset zero
// - enable bit 10 gates checksum two error
// - enable bits 7,6 gate sequence errors
// - enable bit 3 gates voltage dip
// - enable bit 2 gates phase loss
// - second enable word at 04H, reset zero
// - enable bits 15,14 gate neutral flags
// - enable bits 11,10 gate distortion flags
// - enable bit 9 gates harmonic ready
// - enable bits 7..0 gate direction flags
// - first status bit 3 voltage dip
// - first status bits 7,6 sequence errors
`default_nettype none
package event_irq_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_FLAGS_FIRST = 8'h01;
	localparam logic [7:0] ADDR_FLAGS_SECOND = 8'h02;
	localparam logic [7:0] ADDR_EN_FIRST = 8'h03;
	localparam logic [7:0] ADDR_EN_SECOND = 8'h04;
	localparam logic [7:0] ADDR_MODE_FIRST = 8'h05;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [15:0] EN_FIRST_MASK = 16'h04CC;
	localparam logic [15:0] EN_SECOND_MASK = 16'hCEFF;
	localparam logic [15:0] MODE_FIRST_MASK = 16'h0200;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int BIT_SAMPLED_NEUTRAL = 15;
	localparam int BIT_CALC_NEUTRAL = 14;
	localparam int BIT_VOLT_DIST = 11;
	localparam int BIT_CURR_DIST = 10;
	localparam int BIT_HARMONIC = 9;
	localparam int BIT_CHECKSUM_TWO = 10;
	localparam int BIT_VOLT_SEQ = 7;
	localparam int BIT_CURR_SEQ = 6;
	localparam int BIT_DIP = 3;
	localparam int BIT_PHASE_MISSING = 2;
	localparam int BIT_RESOLUTION = 9;
	localparam int DIR_CHANNELS = 8;
	// channel order 7..0: reactive sum,a,b,c then active sum,a,b,c
	localparam int ENERGY_W = 32;
	// fine step 0.01 unit, coarse 0.1 unit, in energy register lsbs
	localparam logic [ENERGY_W-1:0] STEP_FINE = 32'h0000_0001;
	localparam logic [ENERGY_W-1:0] STEP_COARSE = 32'h0000_000A;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [1:0] sel;
		logic [15:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic ack;
		logic [15:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic sampled_neutral_over;
		logic calc_neutral_over;
		logic voltage_distortion_over;
		logic current_distortion_over;
		logic harmonic_result_ready;
		logic checksum_two_error;
		logic voltage_sequence_error;
		logic current_sequence_error;
		logic voltage_dip_flag;
		logic phase_missing_flag;
	} det_t;

	typedef logic [DIR_CHANNELS-1:0][ENERGY_W-1:0] energy_vec_t;
endpackage
`default_nettype wire

// ==== tb/metering_event_status_irq_asserts.sv ====
/*
 checker for the event status and interrupt enable block.
 assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module metering_event_status_irq_asserts
	import event_irq_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic clk_en,
	input wire wb_req_t wb_req,
	input wire wb_rsp_t wb_rsp,
	input wire det_t det,
	input wire energy_vec_t energy,
	input wire logic irq
);
	// ----
	// bus and flag checks
	// ----
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [7:0] last_rd;
	// ff marks no read, as that address is unmapped
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			last_rd <= 8'hFF;
		else if (clk_en)
			last_rd <= (wb_req.cyc && wb_req.stb && !wb_req.we && !wb_rsp.ack) ? wb_req.adr : 8'hFF;
	end
	chk_ack_once: assert property (wb_rsp.ack && clk_en |=> !wb_rsp.ack)
		else $error("ack held too long");
	chk_ack_next: assert property (
		wb_req.cyc && wb_req.stb && clk_en && !wb_rsp.ack |=> wb_rsp.ack)
		else $error("ack late");
	chk_en1_resv: assert property (wb_rsp.ack && last_rd == ADDR_EN_FIRST |->
		(wb_rsp.dat & ~EN_FIRST_MASK) == 16'h0000) else $error("reserved enable bit set");
	chk_en2_resv: assert property (wb_rsp.ack && last_rd == ADDR_EN_SECOND |->
		(wb_rsp.dat & ~EN_SECOND_MASK) == 16'h0000) else $error("reserved enable bit set");
	chk_flag_resv: assert property (wb_rsp.ack && last_rd == ADDR_FLAGS_SECOND |->
		wb_rsp.dat[13:12] == 2'h0 && !wb_rsp.dat[8]) else $error("reserved flag set");
	chk_neutral_seen: assert property (wb_rsp.ack && last_rd == ADDR_FLAGS_SECOND &&
		$past(det.sampled_neutral_over, 2) && $past(clk_en, 2) |-> wb_rsp.dat[BIT_SAMPLED_NEUTRAL])
		else $error("flag lost");
	chk_irq_cause: assert property ($rose(irq) |-> wb_rsp.ack || $past(det) != '0 ||
		$past(energy) != $past(energy, 3)) else $error("irq without cause");
	chk_irq_drop: assert property ($fell(irq) |-> wb_rsp.ack || $past(wb_rsp.ack))
		else $error("irq dropped without access");
	cover property (wb_rsp.ack && last_rd == ADDR_FLAGS_SECOND && wb_rsp.dat != 16'h0000);
	cover property ($rose(irq));
	cover property ($fell(irq));
endmodule
bind metering_event_status_irq metering_event_status_irq_asserts metering_event_status_irq_asserts_i(
	.clk(clk), .nrst(nrst), .clk_en(clk_en), .wb_req(wb_req), .wb_rsp(wb_rsp), .det(det),
	.energy(energy), .irq(irq));
`default_nettype wire

// ==== tb/host_model.sv ====
/*
 host side: a classic wishbone master that services the block.
 assumes the bench calls acc from one process only.
*/
`timescale 1ns/1ps
`default_nettype none
module host_model
	import event_irq_pkg::*;
(
	input wire logic clk,
	input wire wb_rsp_t wb_rsp,
	output var wb_req_t wb_req,
	output var logic tmo
);
	// ----
	// single access, held until ack
	// ----
	initial begin
		wb_req = '0;
		tmo = 1'b0;
	end
	// status reads clear, reserved enable bits masked by the block; callers may pass ones
	task automatic acc(input logic we, input logic [7:0] adr, input logic [15:0] wd,
		output logic [15:0] rd);
		int n;
		n = 0;
		@(posedge clk);
		wb_req <= {1'b1, 1'b1, we, adr, 2'h3, wd};
		do begin
			@(posedge clk);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 50);
		rd = wb_rsp.dat;
		wb_req <= '0;
		tmo = (wb_rsp.ack !== 1'b1);
	endtask
endmodule
`default_nettype wire

// ==== tb/metering_event_status_irq_test.sv ====
/*
 self-checking bench for the event status and interrupt enable block.
 assumes the host model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module metering_event_status_irq_test;
	import event_irq_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, tmo, irq;
	wb_req_t wb_req;
	wb_rsp_t wb_rsp;
	det_t det = '0;
	energy_vec_t energy = '0;
	int n_errors = 0, check_count = 0;
	always #12.5 clk = ~clk;
	metering_event_status_irq metering_event_status_irq_i(.clk(clk), .nrst(nrst),
		.clk_en(clk_en), .wb_req(wb_req), .wb_rsp(wb_rsp), .det(det), .energy(energy), .irq(irq));
	host_model host_model_i(.clk(clk), .wb_rsp(wb_rsp), .wb_req(wb_req), .tmo(tmo));
	// ----
	// helpers
	// ----
	task automatic complete_run();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rw(input logic we, input logic [7:0] a, input logic [15:0] wd, exp);
		logic [15:0] rd;
		host_model_i.acc(we, a, wd, rd);
		if (tmo) begin
			n_errors++;
			complete_run();
		end
		if (!we)
			chk(rd, exp);
	endtask
	task automatic pulse(input det_t d);
		@(posedge clk);
		det <= d;
		@(posedge clk);
		det <= '0;
		repeat (2) @(posedge clk);
	endtask
	// irq is looked at on the falling edge, where it has settled
	task automatic chk_irq(input logic exp);
		@(negedge clk);
		chk({15'h0, irq}, {15'h0, exp});
	endtask
	// ----
	// scenarios
	// ----
	task automatic regs_scn();
		rw(0, ADDR_FLAGS_SECOND, 0, RESET_WORD);
		rw(0, ADDR_EN_FIRST, 0, RESET_WORD);
		rw(0, ADDR_EN_SECOND, 0, RESET_WORD);
		rw(1, ADDR_EN_FIRST, 16'hFFFF, 0);
		rw(0, ADDR_EN_FIRST, 0, 16'h04CC);
		rw(1, ADDR_EN_SECOND, 16'hFFFF, 0);
		rw(0, ADDR_EN_SECOND, 0, 16'hCEFF);
		rw(0, 8'h3F, 0, 16'h0000);
		rw(1, ADDR_EN_FIRST, 0, 0);
		rw(1, ADDR_EN_SECOND, 0, 0);
	endtask
	task automatic flags_scn();
		pulse('1);
		chk_irq(1'b0);
		rw(0, ADDR_FLAGS_SECOND, 0, 16'hCE00);
		rw(0, ADDR_FLAGS_SECOND, 0, 16'h0000);
		rw(0, ADDR_FLAGS_FIRST, 0, 16'h04CC);
	endtask
	// both words hold flags; irq must survive the read of the word without the enabled flag
	task automatic irq_scn(input logic [7:0] ea, input logic [15:0] en, input logic second_last);
		pulse('1);
		rw(1, ea, en, 0);
		chk_irq(1'b1);
		if (second_last)
			rw(0, ADDR_FLAGS_FIRST, 0, 16'h04CC);
		else
			rw(0, ADDR_FLAGS_SECOND, 0, 16'hCE00);
		chk_irq(1'b1);
		if (second_last)
			rw(0, ADDR_FLAGS_SECOND, 0, 16'hCE00);
		else
			rw(0, ADDR_FLAGS_FIRST, 0, 16'h04CC);
		chk_irq(1'b0);
		rw(1, ea, 0, 0);
	endtask
	task automatic dir_scn(input logic [31:0] d, input logic [15:0] exp);
		@(posedge clk);
		energy <= {DIR_CHANNELS{d}};
		repeat (3) @(posedge clk);
		energy <= '0;
		repeat (3) @(posedge clk);
		rw(0, ADDR_FLAGS_SECOND, 0, exp);
	endtask
	// detector seen while frozen must not latch; a held detector beats the read clear
	task automatic freeze_scn();
		@(posedge clk);
		clk_en <= 1'b0;
		pulse('1);
		clk_en <= 1'b1;
		rw(0, ADDR_FLAGS_FIRST, 0, RESET_WORD);
		det.sampled_neutral_over <= 1'b1;
		rw(0, ADDR_FLAGS_SECOND, 0, 16'h8000);
		det <= '0;
		rw(0, ADDR_FLAGS_SECOND, 0, 16'h8000);
		rw(0, ADDR_FLAGS_SECOND, 0, RESET_WORD);
	endtask
	task automatic reset_scn();
		rw(1, ADDR_EN_SECOND, 16'h4000, 0);
		rw(1, ADDR_EN_FIRST, 16'h0004, 0);
		pulse('1);
		chk_irq(1'b1);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		chk_irq(1'b0);
		rw(0, ADDR_EN_FIRST, 0, RESET_WORD);
		rw(0, ADDR_EN_SECOND, 0, RESET_WORD);
		rw(0, ADDR_MODE_FIRST, 0, RESET_WORD);
		rw(0, ADDR_FLAGS_SECOND, 0, RESET_WORD);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		regs_scn();
		flags_scn();
		irq_scn(ADDR_EN_SECOND, 16'h4000, 1'b1);
		irq_scn(ADDR_EN_FIRST, 16'h0004, 1'b0);
		dir_scn(32'h5, 16'h0000);
		dir_scn(32'hA, 16'h00FF);
		rw(1, ADDR_MODE_FIRST, 16'h0200, 0);
		dir_scn(32'h1, 16'h00FF);
		freeze_scn();
		reset_scn();
		complete_run();
	end
endmodule
`default_nettype wire
